// [fpm_cfg.svh]
// front panel menu constants: timing counts, field widths, codes
// assumes a 40 MHz system clock
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH

// ****************************************
// timing
// ****************************************
`define FPM_CLK_KHZ 40000
`define FPM_HOLD_MS 5000
`define FPM_HOLD_CYCLES ((`FPM_HOLD_MS) * (`FPM_CLK_KHZ))
`define FPM_DASH_STEPS 5

// ****************************************
// value layout
// ****************************************
`define FPM_DIGITS 5
`define FPM_DIGIT_W 4
`define FPM_VALUE_W 20
`define FPM_POINT_W 3
`define FPM_NUM_W 10
`define FPM_DIGIT_MAX 4'h9

// ****************************************
// key vector positions
// ****************************************
`define FPM_KEY_MODE 0
`define FPM_KEY_SHIFT 1
`define FPM_KEY_UP 2
`define FPM_KEY_DOWN 3
`define FPM_KEY_DATA 4
`define FPM_KEYS 5

// ****************************************
// setting values
// ****************************************
`define FPM_NV_AUTO_ON 1'b1

`endif

// [fpm_hold_timer.sv]
// hold-to-confirm timer with growing dash count
// assumes hold is a synchronised key level gated by the caller
`timescale 1ns/1ps
`default_nettype none
`include "fpm_cfg.svh"

module fpm_hold_timer #(
  parameter int HOLD_CYCLES = `FPM_HOLD_CYCLES,
  parameter int STEPS = `FPM_DASH_STEPS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hold,
  output logic [`FPM_POINT_W-1:0] dashes,
  output logic fire
);

  localparam int STEP_CYCLES = (HOLD_CYCLES + STEPS - 1) / STEPS;

  logic [31:0] count_q;
  logic [31:0] step_q;
  logic [`FPM_POINT_W-1:0] dash_q;
  logic done_q;
  logic step_end;

  assign step_end = (step_q == 32'(STEP_CYCLES - 1));
  assign dashes = dash_q;
  assign fire = hold && !done_q && (count_q == 32'(HOLD_CYCLES - 1));

  // ****************************************
  // release clears the timer and dashes
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset || !hold) begin
      count_q <= '0;
      step_q <= '0;
      dash_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      count_q <= count_q + 32'h0000_0001;
      step_q <= step_end ? 32'h0000_0000 : step_q + 32'h0000_0001;
      if (step_end && dash_q != `FPM_POINT_W'(STEPS)) begin
        dash_q <= dash_q + `FPM_POINT_W'(1);
      end
      done_q <= fire;
    end
  end

endmodule // fpm_hold_timer

`default_nettype wire

// [fpm_key_sync.sv]
// front panel key synchroniser with press detection
// assumes keys are asynchronous, active high while pressed
`timescale 1ns/1ps
`default_nettype none

module fpm_key_sync #(
  parameter int WIDTH = 5
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] key_pin,
  output logic [WIDTH-1:0] key_level,
  output logic [WIDTH-1:0] key_press
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;
  logic [WIDTH-1:0] agree;

  // ****************************************
  // a change counts once stages two and three agree
  // ****************************************
  assign agree = ~(s2_q ^ s3_q);
  assign level_d = (agree & s3_q) | (~agree & level_q);
  assign key_level = level_q;
  assign key_press = level_d & ~level_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= key_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

endmodule // fpm_key_sync

`default_nettype wire

// [fpm_menu.sv]
// front panel parameter menu: edit, save, nonvolatile write, alarm clear
// assumes a parameter store, nonvolatile writer and alarm logic outside
//
// Functional notes
// - data key shows stored parameter value
// - shift moves point, up/down change digit
// - data key during edit stores value
// - mode key discards edit, back to selection
// - data after save returns to setting display
// - saved value applied now unless restart needed
// - restart-needed parameters shown with r mark
// - auto nonvolatile write when select equals one
// - write starts after five second up hold
// - write result finish, reset or error
// - data after result returns to write display
// - default display first, data goes monitor
// - three mode presses reach auxiliary mode
// - alarm clear after five second up hold
// - only clearable alarms may be reset
// - clear shows finish, else error, alarm stays
`timescale 1ns/1ps
`default_nettype none
`include "fpm_cfg.svh"

module fpm_menu
  import fpm_pkg::*;
#(
  parameter int HOLD_CYCLES = `FPM_HOLD_CYCLES,
  parameter int DIGITS = `FPM_DIGITS
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [`FPM_KEYS-1:0] key_pin,
  input wire logic default_display_select,
  input wire logic panel_write_to_nonvolatile_select,
  input wire logic [`FPM_NUM_W-1:0] param_num,
  input wire logic [`FPM_VALUE_W-1:0] stored_value,
  input wire logic needs_restart,
  output fpm_param_type param_wr,
  output logic param_store,
  output logic param_apply,
  output logic nv_start,
  input wire logic nv_done,
  input wire logic nv_ok,
  input wire logic nv_restart_pending,
  output logic alarm_clear,
  input wire logic alarm_clearable,
  input wire logic alarm_done,
  input wire logic alarm_ok,
  output fpm_disp_type disp
);

  // ****************************************
  // digit arithmetic
  // ****************************************
  function automatic logic [`FPM_VALUE_W-1:0] step_digit(
    input logic [`FPM_VALUE_W-1:0] val,
    input logic [`FPM_POINT_W-1:0] pos,
    input logic up
  );
    logic [`FPM_DIGIT_W-1:0] dig;
    logic [`FPM_VALUE_W-1:0] res;
    dig = val[pos*`FPM_DIGIT_W +: `FPM_DIGIT_W];
    res = val;
    if (up) begin
      dig = (dig >= `FPM_DIGIT_MAX) ? 4'h0 : dig + 4'h1;
    end else begin
      dig = (dig == 4'h0) ? `FPM_DIGIT_MAX : dig - 4'h1;
    end
    res[pos*`FPM_DIGIT_W +: `FPM_DIGIT_W] = dig;
    return res;
  endfunction

  // ****************************************
  // keys and hold timer
  // ****************************************
  logic [`FPM_KEYS-1:0] key_level;
  logic [`FPM_KEYS-1:0] key_press;
  logic [`FPM_POINT_W-1:0] dashes;
  logic hold_fire;
  logic hold_en;

  fpm_key_sync #(
    .WIDTH(`FPM_KEYS)
  ) u_keys (
    .sys_clk(sys_clk),
    .reset(reset),
    .key_pin(key_pin),
    .key_level(key_level),
    .key_press(key_press)
  );

  fpm_hold_timer #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .STEPS(`FPM_DASH_STEPS)
  ) u_hold (
    .sys_clk(sys_clk),
    .reset(reset),
    .hold(hold_en),
    .dashes(dashes),
    .fire(hold_fire)
  );

  // ****************************************
  // state and registers
  // ****************************************
  fpm_state_type state_q;
  fpm_state_type state_d;
  logic [`FPM_VALUE_W-1:0] edit_q;
  logic [`FPM_VALUE_W-1:0] edit_d;
  logic [`FPM_POINT_W-1:0] point_q;
  logic [`FPM_POINT_W-1:0] point_d;
  logic restart_q;
  logic restart_d;
  fpm_result_type result_q;
  fpm_result_type result_d;
  fpm_param_type wr_q;
  logic store_q;
  logic apply_q;
  logic nv_q;
  logic clr_q;
  logic store_d;
  logic apply_d;
  logic nv_d;
  logic clr_d;

  wire k_mode = key_press[`FPM_KEY_MODE];
  wire k_shift = key_press[`FPM_KEY_SHIFT];
  wire k_up = key_press[`FPM_KEY_UP];
  wire k_down = key_press[`FPM_KEY_DOWN];
  wire k_data = key_press[`FPM_KEY_DATA];
  wire up_held = key_level[`FPM_KEY_UP];
  wire in_hold_screen = (state_q == FPM_S_WRMODE) || (state_q == FPM_S_ALMCLR);
  wire [`FPM_POINT_W-1:0] point_left = (point_q == `FPM_POINT_W'(DIGITS - 1)) ?
                                       '0 : point_q + `FPM_POINT_W'(1);
  wire [`FPM_VALUE_W-1:0] edit_up = step_digit(edit_q, point_q, 1'b1);
  wire [`FPM_VALUE_W-1:0] edit_dn = step_digit(edit_q, point_q, 1'b0);
  wire start_select = default_display_select;

  assign hold_en = in_hold_screen && up_held;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    edit_d = edit_q;
    point_d = point_q;
    restart_d = restart_q;
    result_d = result_q;
    store_d = 1'b0;
    apply_d = 1'b0;
    nv_d = 1'b0;
    clr_d = 1'b0;
    case (state_q)
      FPM_S_DEFAULT: begin
        if (k_data) begin
          state_d = FPM_S_MONITOR;
        end
      end
      FPM_S_MONITOR: begin
        if (k_mode) begin
          state_d = FPM_S_PARSEL;
        end
      end
      FPM_S_PARSEL: begin
        if (k_mode) begin
          state_d = FPM_S_WRSEL;
        end else if (k_data) begin
          state_d = FPM_S_EDIT;
          edit_d = stored_value;
          point_d = '0;
        end
      end
      FPM_S_EDIT: begin
        if (k_mode) begin
          state_d = FPM_S_PARSEL;
        end else if (k_data) begin
          state_d = FPM_S_SAVED;
          store_d = 1'b1;
          apply_d = !needs_restart;
          restart_d = needs_restart;
          nv_d = (panel_write_to_nonvolatile_select == `FPM_NV_AUTO_ON);
        end else if (k_shift) begin
          point_d = point_left;
        end else if (k_up) begin
          edit_d = edit_up;
        end else if (k_down) begin
          edit_d = edit_dn;
        end
      end
      FPM_S_SAVED: begin
        if (k_data) begin
          state_d = FPM_S_PARSEL;
        end
      end
      FPM_S_WRSEL: begin
        if (k_mode) begin
          state_d = FPM_S_AUX;
        end else if (k_data) begin
          state_d = FPM_S_WRMODE;
        end
      end
      FPM_S_WRMODE: begin
        if (hold_fire) begin
          state_d = FPM_S_WRBUSY;
          nv_d = 1'b1;
        end else if (k_data) begin
          state_d = FPM_S_WRSEL;
        end
      end
      FPM_S_WRBUSY: begin
        if (nv_done) begin
          state_d = FPM_S_WRRES;
          result_d = !nv_ok ? FPM_RES_ERROR :
                     nv_restart_pending ? FPM_RES_RESET : FPM_RES_FINISH;
        end
      end
      FPM_S_WRRES: begin
        if (k_data) begin
          state_d = FPM_S_WRMODE;
          result_d = FPM_RES_NONE;
        end
      end
      FPM_S_AUX: begin
        if (k_mode) begin
          state_d = FPM_S_MONITOR;
        end else if (k_data) begin
          state_d = FPM_S_ALMCLR;
        end
      end
      FPM_S_ALMCLR: begin
        if (hold_fire) begin
          if (alarm_clearable) begin
            state_d = FPM_S_ALMBUSY;
            clr_d = 1'b1;
          end else begin
            state_d = FPM_S_ALMRES;
            result_d = FPM_RES_ERROR;
          end
        end else if (k_data) begin
          state_d = FPM_S_AUX;
        end
      end
      FPM_S_ALMBUSY: begin
        if (alarm_done) begin
          state_d = FPM_S_ALMRES;
          result_d = alarm_ok ? FPM_RES_FINISH : FPM_RES_ERROR;
        end
      end
      FPM_S_ALMRES: begin
        if (k_data) begin
          state_d = FPM_S_AUX;
          result_d = FPM_RES_NONE;
        end
      end
      default: begin
        state_d = FPM_S_DEFAULT;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= FPM_S_DEFAULT;
      edit_q <= '0;
      point_q <= '0;
      restart_q <= 1'b0;
      result_q <= FPM_RES_NONE;
      store_q <= 1'b0;
      apply_q <= 1'b0;
      nv_q <= 1'b0;
      clr_q <= 1'b0;
      wr_q <= '0;
    end else begin
      state_q <= state_d;
      edit_q <= edit_d;
      point_q <= point_d;
      restart_q <= restart_d;
      result_q <= result_d;
      store_q <= store_d;
      apply_q <= apply_d;
      nv_q <= nv_d;
      clr_q <= clr_d;
      if (store_d) begin
        wr_q <= '{num: param_num, value: edit_q};
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign param_wr = wr_q;
  assign param_store = store_q;
  assign param_apply = apply_q;
  assign nv_start = nv_q;
  assign alarm_clear = clr_q;

  always_comb begin
    disp.screen = state_q;
    disp.value = (state_q == FPM_S_DEFAULT) ? `FPM_VALUE_W'(start_select) : edit_q;
    disp.point = point_q;
    disp.dashes = in_hold_screen ? dashes : '0;
    disp.restart_mark = (state_q == FPM_S_SAVED || state_q == FPM_S_PARSEL) && restart_q;
    disp.result = result_q;
  end

endmodule // fpm_menu

`default_nettype wire

// [fpm_menu_bench.sv]
// testbench for the front panel menu
// assumes fpm_operator as far side, short hold count for simulation
`include "fpm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fpm_menu_bench;
  import fpm_pkg::*;
  localparam int HOLD = 50;
  localparam int K_MODE = `FPM_KEY_MODE;
  localparam int K_SHIFT = `FPM_KEY_SHIFT;
  localparam int K_UP = `FPM_KEY_UP;
  localparam int K_DOWN = `FPM_KEY_DOWN;
  localparam int K_DATA = `FPM_KEY_DATA;
  logic sys_clk, reset, dsel, nvsel, needs_restart, nv_ok, nv_pend, clearable, alarm_ok;
  logic nv_done, alarm_done, param_store, param_apply, nv_start, alarm_clear;
  logic [`FPM_KEYS-1:0] key_pin;
  logic [`FPM_NUM_W-1:0] param_num;
  logic [`FPM_VALUE_W-1:0] stored_value;
  fpm_param_type param_wr;
  fpm_disp_type disp;
  int miscompares = 0, total_checks = 0, cycles = 0;
  int n_store = 0, n_apply = 0, n_nv = 0, n_clr = 0;

  fpm_menu #(.HOLD_CYCLES(HOLD)) i_fpm_menu (.sys_clk(sys_clk), .reset(reset),
    .key_pin(key_pin), .default_display_select(dsel),
    .panel_write_to_nonvolatile_select(nvsel), .param_num(param_num),
    .stored_value(stored_value), .needs_restart(needs_restart), .param_wr(param_wr),
    .param_store(param_store), .param_apply(param_apply), .nv_start(nv_start),
    .nv_done(nv_done), .nv_ok(nv_ok), .nv_restart_pending(nv_pend),
    .alarm_clear(alarm_clear), .alarm_clearable(clearable), .alarm_done(alarm_done),
    .alarm_ok(alarm_ok), .disp(disp));
  fpm_operator i_fpm_operator (.sys_clk(sys_clk), .nv_start(nv_start),
    .alarm_clear(alarm_clear), .key_pin(key_pin), .nv_done(nv_done),
    .alarm_done(alarm_done));

  // ****************************************
  // clock, pulse counts, timeout
  // ****************************************
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    n_store += param_store;
    n_apply += param_apply;
    n_nv += nv_start;
    n_clr += alarm_clear;
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic scr(input fpm_state_type s);
    check(32'(disp.screen), 32'(s));
  endtask
  task automatic k(input int n);
    i_fpm_operator.press(n, 6);
  endtask
  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_entry();
    scr(FPM_S_DEFAULT);
    check(32'(disp.value), 32'h0000_0001);
    k(K_DATA);
    scr(FPM_S_MONITOR);
    repeat (3) k(K_MODE);
    scr(FPM_S_AUX);
    k(K_MODE);
    k(K_MODE);
  endtask
  task automatic t_edit();
    k(K_DATA);
    scr(FPM_S_EDIT);
    check(32'(disp.value), 32'h0000_0190);
    k(K_UP);
    k(K_SHIFT);
    check(32'(disp.point), 32'h0000_0001);
    k(K_DOWN);
    check(32'(disp.value), 32'h0000_0181);
    k(K_DATA);
    check(32'(param_wr), {2'b00, param_num, 20'h0_0181});
    check(n_store * 16 + n_apply * 4 + n_nv, 32'h0000_0014);
    k(K_DATA);
    scr(FPM_S_PARSEL);
  endtask
  task automatic t_restart();
    k(K_DATA);
    k(K_UP);
    k(K_MODE);
    scr(FPM_S_PARSEL);
    check(n_store, 1);
    k(K_DATA);
    k(K_DATA);
    check(n_store * 16 + n_apply * 4 + n_nv, 32'h0000_0025);
    k(K_DATA);
    check(32'(disp.restart_mark), 1);
  endtask
  task automatic t_write();
    fpm_result_type res [3] = '{FPM_RES_FINISH, FPM_RES_RESET, FPM_RES_ERROR};
    k(K_MODE);
    k(K_DATA);
    fork
      i_fpm_operator.press(K_UP, 20);
      begin
        repeat (20) @(posedge sys_clk);
        check(32'(disp.dashes), 1);
      end
    join
    check(n_nv, 1);
    check(32'(disp.dashes), 0);
    for (int i = 0; i < 3; i++) begin
      nv_ok <= (i != 2);
      nv_pend <= (i == 1);
      i_fpm_operator.press(K_UP, 70);
      check(n_nv, 2 + i);
      scr(FPM_S_WRRES);
      check(32'(disp.result), 32'(res[i]));
      k(K_DATA);
      scr(FPM_S_WRMODE);
    end
  endtask
  task automatic t_alarm();
    k(K_DATA);
    k(K_MODE);
    for (int i = 0; i < 3; i++) begin
      clearable <= (i != 2);
      alarm_ok <= (i == 0);
      k(K_DATA);
      i_fpm_operator.press(K_UP, 70);
      check(n_clr, (i == 0) ? 1 : 2);
      scr(FPM_S_ALMRES);
      check(32'(disp.result), (i == 0) ? 32'(FPM_RES_FINISH) : 32'(FPM_RES_ERROR));
      k(K_DATA);
      scr(FPM_S_AUX);
    end
    k(K_DATA);
    scr(FPM_S_ALMCLR);
    k(K_DATA);
    scr(FPM_S_AUX);
    check(n_clr, 2);
  endtask

  initial begin
    reset = 1;
    dsel = 1;
    nvsel = 0;
    needs_restart = 0;
    param_num = 10'h00a;
    stored_value = 20'h0_0190;
    nv_ok = 1;
    nv_pend = 0;
    clearable = 1;
    alarm_ok = 1;
    repeat (3) @(posedge sys_clk);
    reset <= 0;
    t_entry();
    t_edit();
    needs_restart <= 1;
    nvsel <= 1;
    t_restart();
    needs_restart <= 0;
    nvsel <= 0;
    t_write();
    t_alarm();
    summarize();
  end
endmodule // fpm_menu_bench
`default_nettype wire

// [fpm_menu_sva.sv]
// checker for the front panel menu, on top module ports only
// assumes one clock domain, sys_clk with synchronous reset
`include "fpm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fpm_menu_sva
  import fpm_pkg::*;
#(
  parameter int HOLD_CYCLES = `FPM_HOLD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [`FPM_KEYS-1:0] key_pin,
  input wire logic needs_restart,
  input wire logic panel_write_to_nonvolatile_select,
  input wire logic param_store,
  input wire logic param_apply,
  input wire logic nv_start,
  input wire logic nv_done,
  input wire logic nv_ok,
  input wire logic nv_restart_pending,
  input wire logic alarm_clear,
  input wire logic alarm_clearable,
  input wire logic alarm_done,
  input wire logic alarm_ok,
  input wire fpm_disp_type disp
);
  // ****************************************
  // helpers
  // ****************************************
  int unsigned held_q;
  fpm_result_type nv_exp;
  assign nv_exp = !nv_ok ? FPM_RES_ERROR :
    (nv_restart_pending ? FPM_RES_RESET : FPM_RES_FINISH);
  always_ff @(posedge sys_clk) begin
    if (reset || !key_pin[`FPM_KEY_UP]) begin
      held_q <= 0;
    end else begin
      held_q <= held_q + 1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ****************************************
  // properties
  // ****************************************
  property p_apply;
    (param_store || param_apply) |-> param_store && (param_apply == !$past(needs_restart));
  endproperty
  a_apply: assert property (p_apply) else $error("apply pulse wrong");
  property p_store;
    param_store |-> disp.screen == FPM_S_SAVED;
  endproperty
  a_store: assert property (p_store) else $error("store outside save");
  property p_auto;
    param_store |-> nv_start == panel_write_to_nonvolatile_select;
  endproperty
  a_auto: assert property (p_auto) else $error("auto write wrong");
  property p_nv_hold;
    nv_start && !param_store |-> disp.screen == FPM_S_WRBUSY && held_q >= HOLD_CYCLES;
  endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("write start early");
  property p_clr_hold;
    alarm_clear |-> disp.screen == FPM_S_ALMBUSY && held_q >= HOLD_CYCLES;
  endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("clear start early");
  property p_clearable;
    alarm_clear |-> $past(alarm_clearable);
  endproperty
  a_clearable: assert property (p_clearable) else $error("clear not allowed");
  property p_nv_res;
    nv_done && disp.screen == FPM_S_WRBUSY |=>
      disp.screen == FPM_S_WRRES && disp.result == $past(nv_exp);
  endproperty
  a_nv_res: assert property (p_nv_res) else $error("write result wrong");
  property p_alm_res;
    alarm_done && disp.screen == FPM_S_ALMBUSY |=> disp.screen == FPM_S_ALMRES &&
      disp.result == ($past(alarm_ok) ? FPM_RES_FINISH : FPM_RES_ERROR);
  endproperty
  a_alm_res: assert property (p_alm_res) else $error("clear result wrong");
  property p_release;
    !key_pin[`FPM_KEY_UP] [*6] |-> disp.dashes == 0;
  endproperty
  a_release: assert property (p_release) else $error("dashes kept");
  c_nv: cover property (nv_done && disp.screen == FPM_S_WRBUSY);
  c_clr: cover property (alarm_clear);
  c_rst: cover property (param_store && !param_apply);
endmodule // fpm_menu_sva

bind fpm_menu fpm_menu_sva #(.HOLD_CYCLES(HOLD_CYCLES)) i_fpm_menu_sva (
  .sys_clk(sys_clk), .reset(reset), .key_pin(key_pin), .needs_restart(needs_restart),
  .panel_write_to_nonvolatile_select(panel_write_to_nonvolatile_select),
  .param_store(param_store), .param_apply(param_apply), .nv_start(nv_start),
  .nv_done(nv_done), .nv_ok(nv_ok), .nv_restart_pending(nv_restart_pending),
  .alarm_clear(alarm_clear), .alarm_clearable(alarm_clearable),
  .alarm_done(alarm_done), .alarm_ok(alarm_ok), .disp(disp));
`default_nettype wire

// [fpm_operator.sv]
// far side model: operator keys, nonvolatile writer and alarm logic acks
// assumes one key pressed at a time, released between presses
`include "fpm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fpm_operator (
  input wire logic sys_clk,
  input wire logic nv_start,
  input wire logic alarm_clear,
  output logic [`FPM_KEYS-1:0] key_pin,
  output logic nv_done,
  output logic alarm_done
);
  logic [2:0] nv_sr = '0;
  logic [2:0] alm_sr = '0;
  initial key_pin = '0;
  // acknowledge three cycles after each start pulse
  always @(posedge sys_clk) begin
    nv_sr <= {nv_sr[1:0], nv_start};
    alm_sr <= {alm_sr[1:0], alarm_clear};
  end
  assign nv_done = nv_sr[2];
  assign alarm_done = alm_sr[2];
  // press one key for n cycles, then release and pause
  task automatic press(input int k, input int n);
    @(posedge sys_clk);
    key_pin[k] <= 1'b1;
    repeat (n) @(posedge sys_clk);
    key_pin[k] <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule // fpm_operator
`default_nettype wire

// [fpm_pkg.sv]
// front panel menu types
// assumes fpm_cfg.svh is on the include path
`include "fpm_cfg.svh"

package fpm_pkg;

  typedef enum logic [12:0] {
    FPM_S_DEFAULT = 13'h0001,
    FPM_S_MONITOR = 13'h0002,
    FPM_S_PARSEL  = 13'h0004,
    FPM_S_EDIT    = 13'h0008,
    FPM_S_SAVED   = 13'h0010,
    FPM_S_WRSEL   = 13'h0020,
    FPM_S_WRMODE  = 13'h0040,
    FPM_S_WRBUSY  = 13'h0080,
    FPM_S_WRRES   = 13'h0100,
    FPM_S_AUX     = 13'h0200,
    FPM_S_ALMCLR  = 13'h0400,
    FPM_S_ALMBUSY = 13'h0800,
    FPM_S_ALMRES  = 13'h1000
  } fpm_state_type;

  typedef enum logic [1:0] {
    FPM_RES_NONE   = 2'h0,
    FPM_RES_FINISH = 2'h1,
    FPM_RES_RESET  = 2'h2,
    FPM_RES_ERROR  = 2'h3
  } fpm_result_type;

  typedef struct packed {
    fpm_state_type screen;
    logic [`FPM_VALUE_W-1:0] value;
    logic [`FPM_POINT_W-1:0] point;
    logic [`FPM_POINT_W-1:0] dashes;
    logic restart_mark;
    fpm_result_type result;
  } fpm_disp_type;

  typedef struct packed {
    logic [`FPM_NUM_W-1:0] num;
    logic [`FPM_VALUE_W-1:0] value;
  } fpm_param_type;

endpackage : fpm_pkg
